// File: core/fdcmd_pkg.sv
// shared constants, types and register map of the floppy command decoder
package fdcmd_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 10;
    localparam int STEP_TIME_US = 3000;
    localparam int STEP_CYCLES = STEP_TIME_US * CLK_FREQ_MHZ;
    localparam logic [6:0] MAX_RECAL_STEPS = 7'h4F;

    // ------------------------------------------------------------------
    // register indices, taken from address bits 5:2
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_PIN_MON_A = 4'h0;
    localparam logic [3:0] IDX_PIN_MON_B = 4'h1;
    localparam logic [3:0] IDX_MOTOR_SEL = 4'h2;
    localparam logic [3:0] IDX_TAPE_ASSIGN = 4'h3;
    localparam logic [3:0] IDX_MAIN_STATUS = 4'h4;
    localparam logic [3:0] IDX_CMD_DATA = 4'h5;
    localparam logic [3:0] IDX_INPUT_PINS = 4'h7;
    localparam logic [3:0] IDX_MODE_CTRL = 4'h8;
    localparam logic [3:0] IDX_IRQ_STATUS = 4'h9;
    localparam logic [3:0] IDX_IRQ_MASK = 4'hA;

    // ------------------------------------------------------------------
    // command codes and field values
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_SPECIFY = 8'h03;
    localparam logic [7:0] CMD_SENSE_DRIVE = 8'h04;
    localparam logic [7:0] CMD_RECAL = 8'h07;
    localparam logic [7:0] CMD_SENSE_INT = 8'h08;
    localparam logic [7:0] CMD_DUMPREG = 8'h0E;
    localparam logic [7:0] CMD_SEEK = 8'h0F;
    localparam logic [7:0] CMD_PERP = 8'h12;
    localparam logic [7:0] CMD_CONFIGURE = 8'h13;
    localparam logic [6:0] CMD_LOCK_LOW = 7'h14;
    localparam logic [7:0] ST0_INVALID = 8'h80;
    localparam logic [7:0] CFG_RESET = 8'h20;
    localparam logic [7:0] PRETRACK_VALUE_RESET = 8'h00;
    localparam logic [7:0] DUMP_SC_EOT = 8'h00;
    localparam logic [3:0] RES_DUMP_LEN = 4'hA;
    localparam int RES_DEPTH = 10;
    localparam int IRQ_SEEK_DONE = 0;
    localparam int IRQ_RESULT = 1;
    localparam int IRQ_INVALID = 2;
    localparam int RATE_SW_RESET = 7;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {FDCMD_IDLE, FDCMD_PARAM, FDCMD_DISPATCH, FDCMD_EXEC,
        FDCMD_RESULT} fdcmd_state_t;

    typedef struct packed {
        logic track_zero_n;
        logic write_prot_n;
        logic index_n;
        logic second_drive_absent;
    } fdcmd_drv_in_t;

    typedef struct packed {
        logic step;
        logic dir_inward;
        logic head_select;
        logic [1:0] drive_sel;
        logic [3:0] motor_on;
    } fdcmd_drv_out_t;
endpackage

// File: core/fdcmd_core.sv
// floppy command decoder, register map and head positioner on avalon-mm
// Contract
// - recalibrate steps selected drive to track 0, interrupts
// - sense interrupt returns status zero, then cylinder
// - seek takes head/drive byte, new cylinder; no result
// - dump registers returns ten settings bytes
// - sense drive status returns status three byte
// - unknown code: no operation, idle, result 80H
// - registers decoded at fixed offsets; pin monitor at zero
// - pin monitor bits depend on compatibility mode
// - first mode bit 7 shows interrupt output
// - first mode bit 6 zero with second drive
// - first mode bit 6 one without second drive
// - byte buffer disabled after reset until configure
`timescale 1ns/1ns
module fdcmd_core
    import fdcmd_pkg::*;
#(
    parameter int STEP_PERIOD = STEP_CYCLES
)(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire fdcmd_drv_in_t drv_in,
    output fdcmd_drv_out_t drv_out,
    output logic [1:0] data_rate,
    output logic fdc_int,
    output logic irq
);
    localparam logic [15:0] STEP_LAST = 16'(STEP_PERIOD - 1);

    // ------------------------------------------------------------------
    // bus slave: one wait cycle, effect at the edge waitrequest is low
    // ------------------------------------------------------------------
    logic ack, next_ack;
    logic [7:0] rdata, next_rdata;
    logic req, acc, wr_acc, rd_acc;
    logic [3:0] idx;
    logic [7:0] wbyte;
    logic [7:0] pin_mon_a, pin_mon_b, main_stat;

    // command engine state
    fdcmd_state_t state, next_state;
    logic [7:0] opcode, next_opcode;
    logic [1:0] pcnt, next_pcnt, need;
    logic [7:0] prm [3];
    logic [7:0] next_prm [3];
    logic [7:0] res [RES_DEPTH];
    logic [7:0] next_res [RES_DEPTH];
    logic [3:0] res_len, next_res_len, res_idx, next_res_idx;
    logic [7:0] present_cylinder [4];
    logic [7:0] next_pcn [4];
    logic [7:0] st0_hold, next_st0_hold, target, next_target;
    logic [1:0] cur_drv, next_cur_drv;
    logic recal, next_recal, next_fdc_int;
    logic [6:0] recal_cnt, next_recal_cnt;
    logic [15:0] step_cnt, next_step_cnt;
    logic step, next_step, dir_in, next_dir_in, head, next_head;
    logic [7:0] srt_hut, next_srt_hut, hlt_nd, next_hlt_nd;
    logic [5:0] perp, next_perp;
    logic lock, next_lock;
    logic [7:0] cfg, next_cfg, pretrack_value, next_pretrack_value;
    logic [7:0] motor_sel, next_motor_sel;
    logic [1:0] tape_sel, next_tape_sel, next_data_rate;
    logic mode_b, next_mode_b;
    logic [2:0] irq_status, next_irq_status, irq_mask, next_irq_mask, irq_set;
    logic step_tick;

    assign req = avs_read || avs_write;
    assign avs_waitrequest = req && !ack;
    assign acc = req && ack;
    assign wr_acc = acc && avs_write;
    assign rd_acc = acc && avs_read;
    assign idx = avs_address[5:2];
    assign wbyte = avs_writedata[7:0];
    assign avs_readdata = {24'h000000, rdata};
    assign irq = |(irq_status & irq_mask);
    assign step_tick = (step_cnt == STEP_LAST);
    assign drv_out = '{step: step, dir_inward: dir_in, head_select: head,
        drive_sel: motor_sel[1:0], motor_on: motor_sel[7:4]};

    // pin monitor views; second layout inverts most pin senses
    always_comb
    begin
        if (!mode_b)
        begin
            pin_mon_a = {fdc_int, drv_in.second_drive_absent, step,
                drv_in.track_zero_n, head, !drv_in.index_n, drv_in.write_prot_n, dir_in};
            pin_mon_b = {2'b11, motor_sel[0], 3'b000, motor_sel[5:4]};
        end
        else
        begin
            pin_mon_a = {fdc_int, 1'b0, step, !drv_in.track_zero_n, !head,
                drv_in.index_n, !drv_in.write_prot_n, !dir_in};
            pin_mon_b = {drv_in.second_drive_absent, motor_sel[1:0] != 2'h1,
                motor_sel[1:0] != 2'h0, 3'b000, motor_sel[1:0] != 2'h3,
                motor_sel[1:0] != 2'h2};
        end
        main_stat = {state != FDCMD_EXEC && state != FDCMD_DISPATCH,
            state == FDCMD_RESULT, 1'b0, state != FDCMD_IDLE,
            (state == FDCMD_EXEC) ? 4'(4'h1 << cur_drv) : 4'h0};
    end

    always_comb
    begin
        next_ack = req && !ack;
        next_rdata = rdata;
        if (req && !ack && avs_read)
        begin
            if (idx == IDX_PIN_MON_A)
                next_rdata = pin_mon_a;
            else if (idx == IDX_PIN_MON_B)
                next_rdata = pin_mon_b;
            else if (idx == IDX_TAPE_ASSIGN)
                next_rdata = {6'h00, tape_sel};
            else if (idx == IDX_MAIN_STATUS)
                next_rdata = main_stat;
            else if (idx == IDX_CMD_DATA)
                next_rdata = (state == FDCMD_RESULT) ? res[res_idx] : 8'h00;
            else if (idx == IDX_MODE_CTRL)
                next_rdata = {7'h00, mode_b};
            else if (idx == IDX_IRQ_STATUS)
                next_rdata = {5'h00, irq_status};
            else if (idx == IDX_IRQ_MASK)
                next_rdata = {5'h00, irq_mask};
            else
                next_rdata = 8'h00;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack <= 1'b0;
            rdata <= 8'h00;
        end
        else
        begin
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // command engine
    // ------------------------------------------------------------------
    always_comb
    begin
        case (opcode)
            CMD_SPECIFY: need = 2'd2;
            CMD_SENSE_DRIVE: need = 2'd1;
            CMD_RECAL: need = 2'd1;
            CMD_SEEK: need = 2'd2;
            CMD_PERP: need = 2'd1;
            CMD_CONFIGURE: need = 2'd3;
            default: need = 2'd0;
        endcase
    end

    always_comb
    begin
        next_state = state;
        next_opcode = opcode;
        next_pcnt = pcnt;
        next_prm = prm;
        next_res = res;
        next_res_len = res_len;
        next_res_idx = res_idx;
        next_pcn = present_cylinder;
        next_st0_hold = st0_hold;
        next_target = target;
        next_cur_drv = cur_drv;
        next_recal = recal;
        next_recal_cnt = recal_cnt;
        next_fdc_int = fdc_int;
        next_step_cnt = step_tick ? 16'h0000 : 16'(step_cnt + 16'h0001);
        next_step = 1'b0;
        next_dir_in = dir_in;
        next_head = head;
        next_srt_hut = srt_hut;
        next_hlt_nd = hlt_nd;
        next_perp = perp;
        next_lock = lock;
        next_cfg = cfg;
        next_pretrack_value = pretrack_value;
        next_motor_sel = motor_sel;
        next_tape_sel = tape_sel;
        next_data_rate = data_rate;
        next_mode_b = mode_b;
        next_irq_mask = irq_mask;
        irq_set = 3'b000;

        case (state)
            FDCMD_IDLE:
                if (wr_acc && idx == IDX_CMD_DATA)
                begin
                    next_opcode = wbyte;
                    next_pcnt = 2'd0;
                    next_state = FDCMD_PARAM;
                end
            FDCMD_PARAM:
                if (pcnt == need)
                    next_state = FDCMD_DISPATCH;
                else if (wr_acc && idx == IDX_CMD_DATA)
                begin
                    next_prm[pcnt] = wbyte;
                    next_pcnt = 2'(pcnt + 2'd1);
                end
            FDCMD_DISPATCH:
            begin
                next_state = FDCMD_IDLE;
                next_res_idx = 4'h0;
                if (opcode == CMD_SPECIFY)
                begin
                    next_srt_hut = prm[0];
                    next_hlt_nd = prm[1];
                end
                else if (opcode == CMD_SENSE_DRIVE)
                begin
                    next_res[0] = {1'b0, !drv_in.write_prot_n, 1'b1,
                        !drv_in.track_zero_n, 1'b1, prm[0][2:0]};
                    next_res_len = 4'h1;
                    next_state = FDCMD_RESULT;
                end
                else if (opcode == CMD_RECAL || opcode == CMD_SEEK)
                begin
                    next_cur_drv = prm[0][1:0];
                    next_head = (opcode == CMD_SEEK) && prm[0][2];
                    next_target = (opcode == CMD_SEEK) ? prm[1] : 8'h00;
                    next_recal = (opcode == CMD_RECAL);
                    next_recal_cnt = 7'h00;
                    next_state = FDCMD_EXEC;
                end
                else if (opcode == CMD_SENSE_INT)
                begin
                    if (fdc_int)
                    begin
                        next_res[0] = st0_hold;
                        next_res[1] = present_cylinder[st0_hold[1:0]];
                        next_res_len = 4'h2;
                        next_fdc_int = 1'b0;
                    end
                    else
                    begin
                        next_res[0] = ST0_INVALID;
                        next_res_len = 4'h1;
                    end
                    next_state = FDCMD_RESULT;
                end
                else if (opcode == CMD_DUMPREG)
                begin
                    for (int i = 0; i < 4; i++)
                        next_res[i] = present_cylinder[i];
                    next_res[4] = srt_hut;
                    next_res[5] = hlt_nd;
                    next_res[6] = DUMP_SC_EOT;
                    next_res[7] = {lock, 1'b0, perp};
                    next_res[8] = cfg;
                    next_res[9] = pretrack_value;
                    next_res_len = RES_DUMP_LEN;
                    next_state = FDCMD_RESULT;
                end
                else if (opcode == CMD_PERP)
                    next_perp = prm[0][5:0];
                else if (opcode == CMD_CONFIGURE)
                begin
                    next_cfg = {1'b0, prm[1][6:0]};
                    next_pretrack_value = prm[2];
                end
                else if (opcode[6:0] == CMD_LOCK_LOW)
                begin
                    next_lock = opcode[7];
                    next_res[0] = {3'b000, opcode[7], 4'h0};
                    next_res_len = 4'h1;
                    next_state = FDCMD_RESULT;
                end
                else
                begin
                    next_res[0] = ST0_INVALID;
                    next_res_len = 4'h1;
                    irq_set[IRQ_INVALID] = 1'b1;
                    next_state = FDCMD_RESULT;
                end
                if (next_state == FDCMD_RESULT)
                    irq_set[IRQ_RESULT] = 1'b1;
            end
            FDCMD_EXEC:
                if (step_tick)
                begin
                    // recal trusts the track zero pin, seek trusts the count
                    if (recal ? !drv_in.track_zero_n : present_cylinder[cur_drv] == target)
                    begin
                        next_pcn[cur_drv] = target;
                        next_st0_hold = {3'b001, 1'b0, 1'b0, head, cur_drv};
                        next_fdc_int = 1'b1;
                        irq_set[IRQ_SEEK_DONE] = 1'b1;
                        next_state = FDCMD_IDLE;
                    end
                    else if (recal && recal_cnt == MAX_RECAL_STEPS)
                    begin
                        next_st0_hold = {3'b011, 1'b1, 1'b0, head, cur_drv};
                        next_fdc_int = 1'b1;
                        irq_set[IRQ_SEEK_DONE] = 1'b1;
                        next_state = FDCMD_IDLE;
                    end
                    else
                    begin
                        next_step = 1'b1;
                        next_recal_cnt = 7'(recal_cnt + 7'h01);
                        next_dir_in = !recal && target > present_cylinder[cur_drv];
                        if (!recal)
                            next_pcn[cur_drv] = next_dir_in ? 8'(present_cylinder[cur_drv] + 8'h01)
                                : 8'(present_cylinder[cur_drv] - 8'h01);
                    end
                end
            FDCMD_RESULT:
                if (rd_acc && idx == IDX_CMD_DATA)
                begin
                    next_res_idx = 4'(res_idx + 4'h1);
                    if (res_idx == 4'(res_len - 4'h1))
                        next_state = FDCMD_IDLE;
                end
            default:
                next_state = FDCMD_IDLE;
        endcase

        if (wr_acc)
        begin
            if (idx == IDX_MOTOR_SEL)
                next_motor_sel = wbyte;
            else if (idx == IDX_TAPE_ASSIGN)
                next_tape_sel = wbyte[1:0];
            else if (idx == IDX_MAIN_STATUS || idx == IDX_INPUT_PINS)
                next_data_rate = wbyte[1:0];
            else if (idx == IDX_MODE_CTRL)
                next_mode_b = wbyte[0];
            else if (idx == IDX_IRQ_MASK)
                next_irq_mask = wbyte[2:0];
        end
        // software reset aborts the engine but keeps stored settings
        if (wr_acc && idx == IDX_MAIN_STATUS && wbyte[RATE_SW_RESET])
        begin
            next_state = FDCMD_IDLE;
            next_fdc_int = 1'b0;
        end
        // a new event wins over a write-one clear in the same cycle
        next_irq_status = irq_status | irq_set;
        if (wr_acc && idx == IDX_IRQ_STATUS)
            next_irq_status = (irq_status & ~wbyte[2:0]) | irq_set;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= FDCMD_IDLE;
            opcode <= 8'h00;
            pcnt <= 2'd0;
            prm <= '{default: 8'h00};
            res <= '{default: 8'h00};
            res_len <= 4'h0;
            res_idx <= 4'h0;
            present_cylinder <= '{default: 8'h00};
            st0_hold <= 8'h00;
            target <= 8'h00;
            cur_drv <= 2'h0;
            recal <= 1'b0;
            recal_cnt <= 7'h00;
            fdc_int <= 1'b0;
            step_cnt <= 16'h0000;
            step <= 1'b0;
            dir_in <= 1'b0;
            head <= 1'b0;
            srt_hut <= 8'h00;
            hlt_nd <= 8'h00;
            perp <= 6'h00;
            lock <= 1'b0;
            cfg <= CFG_RESET;
            pretrack_value <= PRETRACK_VALUE_RESET;
            motor_sel <= 8'h00;
            tape_sel <= 2'h0;
            data_rate <= 2'h0;
            mode_b <= 1'b0;
            irq_status <= 3'b000;
            irq_mask <= 3'b000;
        end
        else
        begin
            state <= next_state;
            opcode <= next_opcode;
            pcnt <= next_pcnt;
            prm <= next_prm;
            res <= next_res;
            res_len <= next_res_len;
            res_idx <= next_res_idx;
            present_cylinder <= next_pcn;
            st0_hold <= next_st0_hold;
            target <= next_target;
            cur_drv <= next_cur_drv;
            recal <= next_recal;
            recal_cnt <= next_recal_cnt;
            fdc_int <= next_fdc_int;
            step_cnt <= next_step_cnt;
            step <= next_step;
            dir_in <= next_dir_in;
            head <= next_head;
            srt_hut <= next_srt_hut;
            hlt_nd <= next_hlt_nd;
            perp <= next_perp;
            lock <= next_lock;
            cfg <= next_cfg;
            pretrack_value <= next_pretrack_value;
            motor_sel <= next_motor_sel;
            tape_sel <= next_tape_sel;
            data_rate <= next_data_rate;
            mode_b <= next_mode_b;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
        end
    end
endmodule

// File: verif/fdcmd_core_props.sv
// port checker for the command decoder
`timescale 1ns/1ns
module fdcmd_core_props
    import fdcmd_pkg::*;
#(
    parameter int STEP_PERIOD = STEP_CYCLES
)(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire fdcmd_drv_in_t drv_in,
    input wire fdcmd_drv_out_t drv_out,
    input wire logic [1:0] data_rate,
    input wire logic fdc_int,
    input wire logic irq
);
    logic wr_done;
    logic rd_done;
    logic [3:0] idx;
    assign wr_done = avs_write && !avs_waitrequest;
    assign rd_done = avs_read && !avs_waitrequest;
    assign idx = avs_address[5:2];
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    one_wait_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait");
    upper_zero_a: assert property (
        rd_done |-> avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    int_bit_a: assert property (
        rd_done && idx == IDX_PIN_MON_A |-> avs_readdata[7] == $past(fdc_int))
        else $error("pin monitor bit 7 differs from interrupt");
    motor_sel_a: assert property (
        wr_done && idx == IDX_MOTOR_SEL |=> drv_out.drive_sel == $past(avs_writedata[1:0])
        && drv_out.motor_on == $past(avs_writedata[7:4]))
        else $error("motor select write not applied");
    rate_sel_a: assert property (
        wr_done && idx == IDX_INPUT_PINS |=> data_rate == $past(avs_writedata[1:0]))
        else $error("rate write not applied");
    // simulation runs the step period at four clocks
    step_gap_a: assert property (
        drv_out.step |=> !drv_out.step [*3])
        else $error("step pulses too close");
    home_stop_a: assert property (
        drv_out.step && !drv_out.dir_inward |-> drv_in.track_zero_n)
        else $error("outward step at track zero");
    int_clear_a: assert property (
        $fell(fdc_int) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
        else $error("interrupt dropped without a host write");
    cover property (drv_out.step && !drv_out.dir_inward);
    cover property ($rose(fdc_int));
    cover property (rd_done && idx == IDX_CMD_DATA && avs_readdata[7:0] == ST0_INVALID);
endmodule

bind fdcmd_core fdcmd_core_props #(.STEP_PERIOD(STEP_PERIOD)) u_fdcmd_core_props (
    .clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .drv_in(drv_in), .drv_out(drv_out),
    .data_rate(data_rate), .fdc_int(fdc_int), .irq(irq));

// File: verif/fdcmd_drive_model.sv
// drive model: head position and track-zero sensor
`timescale 1ns/1ns
module fdcmd_drive_model
    import fdcmd_pkg::*;
#(
    parameter logic [7:0] START_CYL = 8'h03
)(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire fdcmd_drv_out_t drv_out,
    input wire logic drive2_absent,
    output fdcmd_drv_in_t drv_in,
    output logic [7:0] cyl
);
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            cyl <= START_CYL;
        else if (drv_out.step)
            cyl <= drv_out.dir_inward ? cyl + 8'h01 : cyl - 8'h01;
    end
    // no index pulses: rotation is not modelled
    assign drv_in.track_zero_n = (cyl != 8'h00);
    assign drv_in.write_prot_n = 1'b1;
    assign drv_in.index_n = 1'b1;
    assign drv_in.second_drive_absent = drive2_absent;
endmodule

// File: verif/fdcmd_core_test.sv
// self-checking bench for the command decoder
`timescale 1ns/1ns
module fdcmd_core_test;
    import fdcmd_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic drive2_absent = 1'b1;
    logic fdc_int;
    logic irq;
    logic [1:0] data_rate;
    logic [7:0] cyl;
    logic [7:0] rd;
    fdcmd_drv_in_t drv_in;
    fdcmd_drv_out_t drv_out;
    int n_errors = 0;
    int compares = 0;
    always #50 clk_sys = ~clk_sys;
    fdcmd_core #(.STEP_PERIOD(4)) u_fdcmd_core (.clk_sys(clk_sys), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .drv_in(drv_in), .drv_out(drv_out),
        .data_rate(data_rate), .fdc_int(fdc_int), .irq(irq));
    fdcmd_drive_model u_fdcmd_drive_model (.clk_sys(clk_sys), .arst_n(arst_n),
        .drv_out(drv_out), .drive2_absent(drive2_absent), .drv_in(drv_in), .cyl(cyl));
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, wd};
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n == 50)
            n_errors++;
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic poll(input logic [7:0] m);
        int n;
        n = 0;
        do
        begin
            bus(1'b0, IDX_MAIN_STATUS, 8'h00);
            n++;
        end
        while ((rd & m) !== m && n < 50);
        n_errors += ((rd & m) !== m);
    endtask
    task automatic cmd(input logic [7:0] b);
        poll(8'h80);
        bus(1'b1, IDX_CMD_DATA, b);
    endtask
    task automatic res(input string nm, input logic [7:0] e);
        poll(8'hC0);
        bus(1'b0, IDX_CMD_DATA, 8'h00);
        check(nm, rd, e);
    endtask
    task automatic rdchk(input logic [3:0] idx, input string nm, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        check(nm, rd, e);
    endtask
    task automatic wait_int;
        int n;
        n = 0;
        while (fdc_int !== 1'b1 && n < 400)
        begin
            @(posedge clk_sys);
            n++;
        end
        n_errors += (fdc_int !== 1'b1);
        @(posedge clk_sys);
    endtask
    task automatic dump(input logic [79:0] e);
        cmd(CMD_DUMPREG);
        for (int i = 0; i < 10; i++)
        begin
            poll(8'hC0);
            bus(1'b0, IDX_CMD_DATA, 8'h00);
            check("dump", rd, e[79 - 8 * i -: 8]);
        end
    endtask
    task automatic t_pins;
        rdchk(IDX_PIN_MON_A, "pin_a", 8'h52);
        drive2_absent <= 1'b0;
        rdchk(IDX_PIN_MON_A, "pin_a", 8'h12);
        drive2_absent <= 1'b1;
        bus(1'b1, IDX_MODE_CTRL, 8'h01);
        rdchk(IDX_PIN_MON_A, "pin_a mode2", 8'h0D);
        bus(1'b1, IDX_MODE_CTRL, 8'h00);
        bus(1'b1, IDX_TAPE_ASSIGN, 8'hFF);
        rdchk(IDX_TAPE_ASSIGN, "tape", 8'h03);
        bus(1'b1, IDX_INPUT_PINS, 8'h02);
        rdchk(4'h6, "unmapped", 8'h00);
        $display("pins done");
    endtask
    task automatic t_recal;
        bus(1'b1, IDX_IRQ_MASK, 8'h07);
        bus(1'b1, IDX_MOTOR_SEL, 8'h10);
        cmd(CMD_RECAL);
        cmd(8'h00);
        wait_int();
        check("cyl", cyl, 8'h00);
        check("irq", {7'h0, irq}, 8'h01);
        rdchk(IDX_PIN_MON_A, "pin_a", 8'hC2);
        cmd(CMD_SENSE_INT);
        res("st0", 8'h20);
        res("pcn", 8'h00);
        check("fdc_int", {7'h0, fdc_int}, 8'h00);
        bus(1'b1, IDX_IRQ_MASK, 8'h00);
        @(posedge clk_sys);
        check("irq masked", {7'h0, irq}, 8'h00);
        bus(1'b1, IDX_IRQ_STATUS, 8'h07);
        bus(1'b1, IDX_IRQ_MASK, 8'h07);
        rdchk(IDX_IRQ_STATUS, "irq clear", 8'h00);
        check("irq", {7'h0, irq}, 8'h00);
        $display("recal done");
    endtask
    task automatic t_seek;
        cmd(CMD_SEEK);
        cmd(8'h05);
        cmd(8'h05);
        wait_int();
        check("cyl", cyl, 8'h05);
        check("head", {7'h0, drv_out.head_select}, 8'h01);
        cmd(CMD_SENSE_INT);
        res("st0", 8'h25);
        res("pcn", 8'h05);
        cmd(CMD_SENSE_INT);
        res("st0 none", ST0_INVALID);
        cmd(CMD_SENSE_DRIVE);
        cmd(8'h06);
        res("st3", 8'h2E);
        $display("seek done");
    endtask
    task automatic t_config;
        dump({8'h00, 8'h05, 32'h0, 8'h00, 8'h00, CFG_RESET, PRETRACK_VALUE_RESET});
        cmd(CMD_CONFIGURE);
        cmd(8'h00);
        cmd(8'h47);
        cmd(8'h33);
        poll(8'h80);
        check("no result", {7'h0, rd[6]}, 8'h00);
        cmd(8'h94);
        res("lock", 8'h10);
        cmd(CMD_SPECIFY);
        cmd(8'hA1);
        cmd(8'h02);
        cmd(CMD_PERP);
        cmd(8'h05);
        dump({8'h00, 8'h05, 16'h0, 8'hA1, 8'h02, 8'h00, 8'h85, 8'h47, 8'h33});
        cmd(8'h14);
        res("unlock", 8'h00);
        $display("config done");
    endtask
    task automatic t_invalid;
        for (int i = 0; i < 2; i++)
        begin
            cmd(i == 0 ? 8'h00 : 8'h1B);
            res("invalid", ST0_INVALID);
            rdchk(IDX_MAIN_STATUS, "standby", 8'h80);
        end
        bus(1'b0, IDX_IRQ_STATUS, 8'h00);
        check("irq invalid", {7'h0, rd[2]}, 8'h01);
        $display("invalid done");
    endtask
    task automatic finish_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_pins();
        t_recal();
        t_seek();
        t_config();
        t_invalid();
        finish_test();
    end
    initial
    begin
        #2000000;
        n_errors++;
        finish_test();
    end
endmodule
